//--- vcspc_top.sv
// Video clock source, sync polarity and shared pin control block
`timescale 1ns/10ps
module vcspc_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire vcspc_pkg::vcspc_pins_in_t pins_in,
  input wire logic [7:0] pixel_data_in,
  output vcspc_pkg::vcspc_video_t video_out,
  output logic pixel_clock_out,
  output logic pixel_clock_oe,
  output logic video_clock1_out,
  output logic video_clock1_oe,
  output logic video_clock2_out,
  output logic video_clock2_oe,
  output logic full_scale_adjust_mode,
  output logic ext_clock_mode,
  output logic mem_clock_tick,
  output logic bus_clock_tick,
  output logic palette_clock_tick,
  output logic shift_clock_tick
);
  import vcspc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;

  // Every outside pin passes two flops before use
  vcspc_sync_edge #(.W(PIN_COUNT)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(pins_in),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] misc_out;
  logic [7:0] dac_select_reg;
  logic [7:0] extender_control_reg;
  logic [7:0] second_ext_reg;
  logic [7:0] pin_control;
  logic [7:0] htotal;
  logic [7:0] hsync_start;
  logic [7:0] hsync_end;
  logic [7:0] vtotal;
  logic [7:0] vsync_start;
  logic [7:0] vsync_end;
  logic dac_ext;
  logic extender_en;
  logic ext_pixel_mode;
  logic [1:0] shift_sel_req;
  logic [1:0] shift_sel;
  logic strap;
  logic [1:0] strap_count;

  assign dac_ext = dac_select_reg[DAC_EXT_BIT];
  assign extender_en = extender_control_reg[EXTENDER_EN_BIT];
  assign ext_pixel_mode = pin_control[PC_EXT_PIXEL_BIT];
  assign shift_sel_req = pin_control[PC_SHIFT_SEL_LSB +: 2];

  // Register writes; reset leaves every mode at its internal default
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      misc_out <= MISC_OUT_RST;
      dac_select_reg <= DAC_SELECT_RST;
      extender_control_reg <= EXT_CONTROL_RST;
      second_ext_reg <= SECOND_EXT_RST;
      pin_control <= PIN_CONTROL_RST;
      htotal <= HTOTAL_RST;
      hsync_start <= HSYNC_START_RST;
      hsync_end <= HSYNC_END_RST;
      vtotal <= VTOTAL_RST;
      vsync_start <= VSYNC_START_RST;
      vsync_end <= VSYNC_END_RST;
    end else if (reg_write) begin
      unique case (reg_addr)
        MISC_OUT_ADDR: misc_out <= reg_wdata;
        DAC_SELECT_ADDR: dac_select_reg <= reg_wdata;
        EXT_CONTROL_ADDR: extender_control_reg <= reg_wdata;
        SECOND_EXT_ADDR: second_ext_reg <= reg_wdata;
        PIN_CONTROL_ADDR: pin_control <= reg_wdata;
        HTOTAL_ADDR: htotal <= reg_wdata;
        HSYNC_START_ADDR: hsync_start <= reg_wdata;
        HSYNC_END_ADDR: hsync_end <= reg_wdata;
        VTOTAL_ADDR: vtotal <= reg_wdata;
        VSYNC_START_ADDR: vsync_start <= reg_wdata;
        VSYNC_END_ADDR: vsync_end <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        MISC_OUT_ADDR: begin
          reg_rdata <= 8'h00;
          reg_rdata[STATUS_SENSE_BIT] <= dac_ext & pin_level[IX_SENSE];
        end
        DAC_SELECT_ADDR: reg_rdata <= dac_select_reg;
        EXT_CONTROL_ADDR: reg_rdata <= extender_control_reg;
        SECOND_EXT_ADDR: reg_rdata <= second_ext_reg;
        PIN_CONTROL_ADDR: reg_rdata <= pin_control;
        BLOCK_STATE_ADDR: reg_rdata <= {3'h0, strap, shift_sel, ext_clock_mode,
                                        full_scale_adjust_mode};
        HTOTAL_ADDR: reg_rdata <= htotal;
        HSYNC_START_ADDR: reg_rdata <= hsync_start;
        HSYNC_END_ADDR: reg_rdata <= hsync_end;
        VTOTAL_ADDR: reg_rdata <= vtotal;
        VSYNC_START_ADDR: reg_rdata <= vsync_start;
        VSYNC_END_ADDR: reg_rdata <= vsync_end;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and clock modes

  // Strap is caught after release, once the synchroniser has settled
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strap_count <= 2'h0;
      strap <= 1'b0;
    end else if (strap_count != STRAP_SETTLE_CYCLES[1:0]) begin
      strap_count <= strap_count + 2'h1;
      strap <= pin_level[IX_STRAP];
    end
  end

  // Clock mode follows the external clock enable level
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_clock_mode <= 1'b0;
    end else begin
      ext_clock_mode <= pin_level[IX_EXT_SELECT];
    end
  end

  // Full-scale adjust owns the shared pin unless the converter is external
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      full_scale_adjust_mode <= 1'b1;
    end else begin
      full_scale_adjust_mode <= ~dac_ext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory and bus clock ticks

  logic [7:0] mem_div;
  logic mem_div_tick;

  // Internal memory clock divider from clk_sys
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_div <= 8'h00;
    end else if (mem_div == 8'(MEM_CLOCK_CYCLES - 1)) begin
      mem_div <= 8'h00;
    end else begin
      mem_div <= mem_div + 8'h01;
    end
  end
  assign mem_div_tick = (mem_div == 8'(MEM_CLOCK_CYCLES - 1));

  // Memory tick source picked per mode, bus tick always from its pin; ticks are pulses, so switching cannot glitch
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_clock_tick <= 1'b0;
      bus_clock_tick <= 1'b0;
    end else begin
      mem_clock_tick <= ext_clock_mode ? pin_rise[IX_MEM_CLOCK] : mem_div_tick;
      bus_clock_tick <= pin_rise[IX_BUS_CLOCK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift clock selection

  logic src_rise;
  logic src_fall;

  // Map a select code to its video clock input index
  function automatic int video_index(input logic [1:0] sel);
    unique case (sel)
      2'h1: video_index = IX_VIDEO1;
      2'h2: video_index = IX_VIDEO2;
      default: video_index = IX_VIDEO0;
    endcase
  endfunction

  // New select taken only while the pixel clock rests low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shift_sel <= 2'h0;
    end else if (!pixel_clock_out && !src_rise) begin
      shift_sel <= shift_sel_req;
    end
  end

  // Internal mode runs from the reference pin, external from the chosen clock
  always_comb begin
    if (ext_pixel_mode) begin
      src_rise = pin_rise[video_index(shift_sel)];
      src_fall = pin_fall[video_index(shift_sel)];
    end else begin
      src_rise = pin_rise[IX_VIDEO0];
      src_fall = pin_fall[IX_VIDEO0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel clock pin and video data

  // Extender mode turns the pixel clock pin into the palette clock input
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pixel_clock_oe <= 1'b0;
      pixel_clock_out <= 1'b0;
      palette_clock_tick <= 1'b0;
      shift_clock_tick <= 1'b0;
    end else begin
      pixel_clock_oe <= ~extender_en;
      palette_clock_tick <= extender_en ? pin_rise[IX_PIXEL_CLOCK] : src_rise;
      shift_clock_tick <= src_rise;
      if (extender_en) begin
        pixel_clock_out <= 1'b0;
      end else if (src_rise) begin
        pixel_clock_out <= 1'b1;
      end else if (src_fall) begin
        pixel_clock_out <= 1'b0; // Falling edge left stable for capture
      end
    end
  end

  // Data updated only with the rising pixel clock edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      video_out.pixel_data <= 8'h00;
    end else if (!extender_en && src_rise) begin
      video_out.pixel_data <= pixel_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync generation

  logic [7:0] hcount;
  logic [7:0] vcount;
  logic h_active;
  logic v_active;

  // Window test shared by both sync timers
  function automatic logic in_window(input logic [7:0] pos, input logic [7:0] first,
                                     input logic [7:0] last);
    in_window = (pos >= first) && (pos < last);
  endfunction

  // Line counter advances on each shift clock, frame counter at each line wrap
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hcount <= 8'h00;
      vcount <= 8'h00;
    end else if (src_rise) begin
      if (hcount >= htotal) begin
        hcount <= 8'h00;
        vcount <= (vcount >= vtotal) ? 8'h00 : vcount + 8'h01;
      end else begin
        hcount <= hcount + 8'h01;
      end
    end
  end

  assign h_active = in_window(hcount, hsync_start, hsync_end);
  assign v_active = in_window(vcount, vsync_start, vsync_end);

  // Polarity bits set means active-low pulses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      video_out.hsync <= 1'b0;
      video_out.vsync <= 1'b0;
    end else begin
      video_out.hsync <= h_active ^ misc_out[MISC_HSYNC_NEG_BIT];
      video_out.vsync <= v_active ^ misc_out[MISC_VSYNC_NEG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared video clock pins

  // Strap gives pins status outputs; otherwise internal mode makes a user output
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      video_clock1_oe <= 1'b0;
      video_clock1_out <= 1'b0;
      video_clock2_oe <= 1'b0;
      video_clock2_out <= 1'b0;
    end else begin
      if (strap) begin
        video_clock1_oe <= 1'b1;
        video_clock1_out <= pin_control[PC_PIN1_LATCH_BIT] ?
                            (ext_pixel_mode & src_rise) : misc_out[MISC_PIN1_BIT];
      end else if (!ext_pixel_mode) begin
        video_clock1_oe <= 1'b1;
        video_clock1_out <= pin_control[PC_USER_OUT1_BIT];
      end else begin
        video_clock1_oe <= 1'b0;
        video_clock1_out <= 1'b0;
      end
      video_clock2_oe <= strap;
      video_clock2_out <= strap & (pin_control[PC_PIN2_SECOND_BIT] ?
                          second_ext_reg[SECOND_USER_BIT] : misc_out[MISC_PIN2_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_dac_mode;
    (reg_write && reg_addr == DAC_SELECT_ADDR && reg_wdata[DAC_EXT_BIT]) |-> ##2
      !full_scale_adjust_mode;
  endproperty
  a_dac_mode: assert property (p_dac_mode) else $error("full-scale mode kept");

  property p_sense_read;
    (reg_read && reg_addr == MISC_OUT_ADDR) |=>
      reg_rdata[STATUS_SENSE_BIT] == ($past(dac_ext) && $past(pin_level[IX_SENSE]));
  endproperty
  a_sense_read: assert property (p_sense_read) else $error("sense bit wrong");

  property p_vsync_pol;
    $past(v_active) |-> video_out.vsync == !$past(misc_out[MISC_VSYNC_NEG_BIT]);
  endproperty
  a_vsync_pol: assert property (p_vsync_pol) else $error("vsync level wrong");

  property p_hsync_pos;
    (src_rise && hcount == hsync_start - 8'h01 && hsync_end > hsync_start &&
     hcount < htotal && $stable(misc_out)) |-> ##2
      video_out.hsync == !misc_out[MISC_HSYNC_NEG_BIT];
  endproperty
  a_hsync_pos: assert property (p_hsync_pos) else $error("hsync not at start");

  property p_data_edge;
    $changed(video_out.pixel_data) |-> $rose(pixel_clock_out);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data off edge");

  property p_extender_in;
    extender_en |=> !pixel_clock_oe && !pixel_clock_out;
  endproperty
  a_extender_in: assert property (p_extender_in) else $error("pixel pin driven");

  property p_mem_clock;
    (ext_clock_mode && pin_rise[IX_MEM_CLOCK]) |=> mem_clock_tick;
  endproperty
  a_mem_clock: assert property (p_mem_clock) else $error("memory tick missed");

  property p_ext_select;
    $rose(pin_level[IX_EXT_SELECT]) |=> ext_clock_mode;
  endproperty
  a_ext_select: assert property (p_ext_select) else $error("clock mode late");

  property p_user_out;
    (!strap && !ext_pixel_mode && $stable(strap)) |=>
      video_clock1_oe && video_clock1_out == $past(pin_control[PC_USER_OUT1_BIT]);
  endproperty
  a_user_out: assert property (p_user_out) else $error("user output wrong");

  property p_strap_pin2;
    strap |=> video_clock2_oe;
  endproperty
  a_strap_pin2: assert property (p_strap_pin2) else $error("pin2 not driven");

  property p_bus_tick;
    pin_rise[IX_BUS_CLOCK] |=> bus_clock_tick;
  endproperty
  a_bus_tick: assert property (p_bus_tick) else $error("bus tick missed");

  property p_reset_mode;
    $fell(reset) |-> !dac_ext && !ext_pixel_mode && !extender_en;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("bad reset mode");

  c_ext_pixel: cover property (ext_pixel_mode && shift_sel == 2'h2 && src_rise);
  c_extender: cover property (extender_en && palette_clock_tick);
  c_vsync: cover property ($rose(v_active));
  c_sense: cover property (reg_read && reg_addr == MISC_OUT_ADDR && dac_ext);
endmodule

//--- vcspc_pkg.sv
// Constants and carrier types for the video clock, sync and pin control block
package vcspc_pkg;

  // Register map (10-bit port addresses, 8-bit data)
  localparam logic [9:0] MISC_OUT_ADDR = 10'h3C2;
  localparam logic [9:0] DAC_SELECT_ADDR = 10'h318;
  localparam logic [9:0] EXT_CONTROL_ADDR = 10'h366;
  localparam logic [9:0] SECOND_EXT_ADDR = 10'h302;
  localparam logic [9:0] PIN_CONTROL_ADDR = 10'h380;
  localparam logic [9:0] BLOCK_STATE_ADDR = 10'h381;
  localparam logic [9:0] HTOTAL_ADDR = 10'h382;
  localparam logic [9:0] HSYNC_START_ADDR = 10'h383;
  localparam logic [9:0] HSYNC_END_ADDR = 10'h384;
  localparam logic [9:0] VTOTAL_ADDR = 10'h385;
  localparam logic [9:0] VSYNC_START_ADDR = 10'h386;
  localparam logic [9:0] VSYNC_END_ADDR = 10'h387;

  // Field positions
  localparam int MISC_PIN1_BIT = 2;
  localparam int MISC_PIN2_BIT = 3;
  localparam int MISC_HSYNC_NEG_BIT = 6;
  localparam int MISC_VSYNC_NEG_BIT = 7;
  localparam int STATUS_SENSE_BIT = 4;
  localparam int DAC_EXT_BIT = 7;
  localparam int EXTENDER_EN_BIT = 7;
  localparam int SECOND_USER_BIT = 1;
  localparam int PC_EXT_PIXEL_BIT = 0;
  localparam int PC_SHIFT_SEL_LSB = 1;
  localparam int PC_PIN1_LATCH_BIT = 3;
  localparam int PC_PIN2_SECOND_BIT = 4;
  localparam int PC_USER_OUT1_BIT = 5;

  // Reset values
  localparam logic [7:0] MISC_OUT_RST = 8'h00;
  localparam logic [7:0] DAC_SELECT_RST = 8'h00;
  localparam logic [7:0] EXT_CONTROL_RST = 8'h00;
  localparam logic [7:0] SECOND_EXT_RST = 8'h00;
  localparam logic [7:0] PIN_CONTROL_RST = 8'h00;
  localparam logic [7:0] HTOTAL_RST = 8'h1F;
  localparam logic [7:0] HSYNC_START_RST = 8'h18;
  localparam logic [7:0] HSYNC_END_RST = 8'h1C;
  localparam logic [7:0] VTOTAL_RST = 8'h0F;
  localparam logic [7:0] VSYNC_START_RST = 8'h0C;
  localparam logic [7:0] VSYNC_END_RST = 8'h0E;

  // Timing: internal memory clock period as printed, cycles derived from 40 MHz
  localparam int CLK_SYS_PERIOD_NS = 25;
  localparam int MEM_CLOCK_PERIOD_NS = 100;
  localparam int MEM_CLOCK_CYCLES = MEM_CLOCK_PERIOD_NS / CLK_SYS_PERIOD_NS;
  localparam int STRAP_SETTLE_CYCLES = 3;

  // Index of each pin input in the synchroniser vector
  localparam int PIN_COUNT = 9;
  localparam int IX_PIXEL_CLOCK = 0;
  localparam int IX_VIDEO0 = 1;
  localparam int IX_VIDEO1 = 2;
  localparam int IX_VIDEO2 = 3;
  localparam int IX_MEM_CLOCK = 4;
  localparam int IX_BUS_CLOCK = 5;
  localparam int IX_SENSE = 6;
  localparam int IX_EXT_SELECT = 7;
  localparam int IX_STRAP = 8;

  // Pins coming from outside the clk_sys domain
  typedef struct packed {
    logic pin_output_strap;
    logic ext_clock_select;
    logic monitor_sense_in;
    logic local_bus_clock_in;
    logic ext_memory_clock_in;
    logic video_clock_in2;
    logic video_clock_in1;
    logic video_clock_in0;
    logic pixel_clock_in;
  } vcspc_pins_in_t;

  // Video output bundle toward the palette converter, panel or monitor
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic [7:0] pixel_data;
  } vcspc_video_t;

endpackage

//--- vcspc_sync_edge.sv
// Two-flop synchroniser bank with edge detection for asynchronous pins
`timescale 1ns/10ps
module vcspc_sync_edge #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta <= '0;
      level <= '0;
      prev <= '0;
    end else begin
      meta <= async_in;
      level <= meta;
      prev <= level;
    end
  end

  // Edges taken from the settled stage only
  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule

//--- vcspc_partner.sv
// Far-side model: clock sources, monitor sense line and pixel latch
`timescale 1ns/10ps
module vcspc_partner (
  input wire logic [5:0] run,
  input wire logic sense_level,
  input wire logic pixel_clock_out,
  input wire vcspc_pkg::vcspc_video_t video_out,
  output logic [5:0] src_clk,
  output logic monitor_sense_in,
  output logic [7:0] captured
);
  import vcspc_pkg::*;

  // Sources stand low between bursts; each burst ends on a whole period
  initial begin
    src_clk = 6'h00;
    forever begin
      wait (run != 6'h00);
      #7;
      while (run != 6'h00) begin
        src_clk = run;
        #100;
        src_clk = 6'h00;
        #100;
      end
    end
  end

  // Monitor drives its sense line as a plain level
  assign monitor_sense_in = sense_level;

  // Converter latches pixel data on the falling pixel clock
  always @(negedge pixel_clock_out) begin
    captured <= video_out.pixel_data;
  end
endmodule

//--- vcspc_tb_top.sv
// Self-checking bench for the video clock, sync and pin control block
`timescale 1ns/10ps
module vcspc_tb_top;
  import vcspc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] pixel_data_in = 8'h00;
  logic strap = 1'b0;
  logic ext_sel = 1'b0;
  logic sense_level = 1'b1;
  logic [5:0] run = 6'h00;
  logic [5:0] src_clk;
  logic monitor_sense_in;
  logic [7:0] captured;
  logic [7:0] reg_rdata;
  vcspc_pins_in_t pins_in;
  vcspc_video_t video_out;
  logic pixel_clock_out, pixel_clock_oe, video_clock1_out, video_clock1_oe;
  logic video_clock2_out, video_clock2_oe, full_scale_adjust_mode, ext_clock_mode;
  logic mem_clock_tick, bus_clock_tick, palette_clock_tick, shift_clock_tick;
  logic tick_prev = 1'b0;
  logic pclk_prev = 1'b0;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_mem, n_bus, n_pal, n_shift, n_hs, n_vs, n_pclk;

  assign pins_in = {strap, ext_sel, monitor_sense_in, src_clk};

  vcspc_top dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pins_in(pins_in), .pixel_data_in(pixel_data_in),
    .video_out(video_out), .pixel_clock_out(pixel_clock_out),
    .pixel_clock_oe(pixel_clock_oe), .video_clock1_out(video_clock1_out),
    .video_clock1_oe(video_clock1_oe), .video_clock2_out(video_clock2_out),
    .video_clock2_oe(video_clock2_oe), .full_scale_adjust_mode(full_scale_adjust_mode),
    .ext_clock_mode(ext_clock_mode), .mem_clock_tick(mem_clock_tick),
    .bus_clock_tick(bus_clock_tick), .palette_clock_tick(palette_clock_tick),
    .shift_clock_tick(shift_clock_tick));

  vcspc_partner far_side (.run(run), .sense_level(sense_level),
    .pixel_clock_out(pixel_clock_out), .video_out(video_out), .src_clk(src_clk),
    .monitor_sense_in(monitor_sense_in), .captured(captured));

  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;

  ////////////////////
  // Tick counters; sync sampled one cycle after each shift tick
  always @(posedge clk_sys) begin
    cycles++;
    n_mem += mem_clock_tick;
    n_bus += bus_clock_tick;
    n_pal += palette_clock_tick;
    n_shift += shift_clock_tick;
    n_pclk += pixel_clock_out && !pclk_prev;
    if (tick_prev) begin
      n_hs += video_out.hsync;
      n_vs += video_out.vsync;
    end
    tick_prev = shift_clock_tick;
    pclk_prev = pixel_clock_out;
    pixel_data_in <= pixel_data_in + 8'h01;
    if (cycles == 40000) begin
      mismatches++;
      final_report();
    end
  end

  ////////////////////
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk_sys);
    reset <= 1'b1;
    strap <= s;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  // Burst of whole source periods, then settle past the synchronisers
  task automatic run_src(input logic [5:0] m, input int periods);
    @(negedge clk_sys);
    {n_mem, n_bus, n_pal, n_shift, n_hs, n_vs, n_pclk} = '0;
    @(posedge clk_sys);
    run <= m;
    repeat (periods * 8 - 1) @(posedge clk_sys);
    run <= 6'h00;
    repeat (10) @(posedge clk_sys);
  endtask

  ////////////////////
  task automatic t_defaults();
    logic [7:0] d;
    check(full_scale_adjust_mode, 1);
    check(ext_clock_mode, 0);
    rd(BLOCK_STATE_ADDR, d);
    check(d, 8'h01);
    rd(EXT_CONTROL_ADDR, d);
    check(d, 8'h00);
    rd(HSYNC_START_ADDR, d);
    check(d, 8'h18);
    rd(10'h3FF, d);
    check(d, 8'h00);
  endtask

  task automatic t_sense();
    logic [7:0] d;
    @(posedge clk_sys);
    sense_level <= 1'b0;
    rd(MISC_OUT_ADDR, d);
    check(d, 8'h00);
    wr(DAC_SELECT_ADDR, 8'h80);
    repeat (2) @(negedge clk_sys);
    check(full_scale_adjust_mode, 0);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      sense_level <= s[0];
      repeat (6) @(posedge clk_sys);
      rd(MISC_OUT_ADDR, d);
      check(d, s ? 8'h10 : 8'h00);
    end
    wr(DAC_SELECT_ADDR, 8'h00);
    repeat (2) @(negedge clk_sys);
    check(full_scale_adjust_mode, 1);
  endtask

  task automatic t_clock();
    logic [7:0] d;
    @(posedge clk_sys);
    ext_sel <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(ext_clock_mode, 1);
    rd(BLOCK_STATE_ADDR, d);
    check(d[1], 1);
    run_src(6'h30, 10);
    check(n_mem, 10);
    check(n_bus, 10);
    // Internal mode: divider ticks only, the toggling pin is ignored
    ext_sel <= 1'b0;
    run <= 6'h10;
    repeat (8) @(posedge clk_sys);
    check(ext_clock_mode, 0);
    @(negedge clk_sys);
    n_mem = 0;
    repeat (40) @(posedge clk_sys);
    @(negedge clk_sys);
    check(n_mem, 40 / MEM_CLOCK_CYCLES);
    run <= 6'h00;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic pin_case(input logic [7:0] pc, input logic [7:0] misc,
                          input logic [7:0] sec, input logic [3:0] exp);
    wr(PIN_CONTROL_ADDR, pc);
    wr(MISC_OUT_ADDR, misc);
    wr(SECOND_EXT_ADDR, sec);
    repeat (3) @(negedge clk_sys);
    check({video_clock1_oe, video_clock1_out, video_clock2_oe, video_clock2_out}, exp);
  endtask

  // Data may only move with a rising pixel clock and must hold through its fall
  task automatic t_pixel();
    logic prev_pc;
    logic [7:0] prev_pd;
    logic [7:0] rise_pd;
    prev_pc = pixel_clock_out;
    prev_pd = video_out.pixel_data;
    rise_pd = prev_pd;
    run_src(6'h00, 1);
    @(posedge clk_sys);
    run <= 6'h02;
    repeat (400) begin
      @(negedge clk_sys);
      if (video_out.pixel_data !== prev_pd)
        check(pixel_clock_out && !prev_pc, 1);
      if (pixel_clock_out && !prev_pc) begin
        rise_pd = video_out.pixel_data;
        check(rise_pd, 8'(pixel_data_in - 8'h01));
      end
      if (!pixel_clock_out && prev_pc) check(captured, rise_pd);
      prev_pc = pixel_clock_out;
      prev_pd = video_out.pixel_data;
    end
    run <= 6'h00;
    check(n_pclk > 40, 1);
    check(pixel_clock_oe, 1);
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic t_sync();
    wr(PIN_CONTROL_ADDR, 8'h04);
    wr(HSYNC_START_ADDR, 8'h02);
    wr(HSYNC_END_ADDR, 8'h07);
    wr(VSYNC_START_ADDR, 8'h03);
    wr(VSYNC_END_ADDR, 8'h06);
    for (int p = 0; p < 2; p++) begin
      wr(MISC_OUT_ADDR, p ? 8'hC0 : 8'h00);
      run_src(6'h02, 512);
      check(n_shift, 512);
      check(p ? 512 - n_hs : n_hs, 80);
      check(p ? 512 - n_vs : n_vs, 96);
    end
  endtask

  task automatic t_shift();
    logic [1:0] map [4] = '{2'd0, 2'd1, 2'd2, 2'd0};
    for (int sel = 0; sel < 4; sel++) begin
      wr(PIN_CONTROL_ADDR, {5'h00, sel[1:0], 1'b1});
      for (int src = 0; src < 3; src++) begin
        run_src(6'h02 << src, 4);
        check(n_shift, map[sel] == src ? 4 : 0);
      end
    end
  endtask

  task automatic t_extender();
    wr(EXT_CONTROL_ADDR, 8'h80);
    run_src(6'h03, 10);
    check(n_pal, 10);
    check(n_pclk, 0);
    check(pixel_clock_oe, 0);
    wr(EXT_CONTROL_ADDR, 8'h00);
  endtask

  ////////////////////
  // Main sequence
  initial begin
    do_reset(1'b0);
    t_defaults();
    t_sense();
    t_clock();
    pin_case(8'h20, 8'h00, 8'h00, 4'b1100);
    pin_case(8'h00, 8'h04, 8'h00, 4'b1000);
    pin_case(8'h21, 8'h00, 8'h00, 4'b0000);
    t_pixel();
    t_sync();
    t_shift();
    t_extender();
    do_reset(1'b1);
    pin_case(8'h00, 8'h04, 8'h00, 4'b1110);
    pin_case(8'h00, 8'h08, 8'h00, 4'b1011);
    pin_case(8'h10, 8'h00, 8'h02, 4'b1011);
    pin_case(8'h10, 8'h08, 8'h00, 4'b1010);
    pin_case(8'h09, 8'h04, 8'h00, 4'b1010);
    final_report();
  end
endmodule
